// [inc/cpufifo_params.svh]
// constants of the processor-facing fifo port
`ifndef CPUFIFO_PARAMS_SVH
`define CPUFIFO_PARAMS_SVH
`define CPUFIFO_DATA_W 8
`define CPUFIFO_BUF_BYTES 1024
`define CPUFIFO_BUF_AW 10
`define CPUFIFO_SYNC_STAGES 2
`define CPUFIFO_SEL_DATA 1'b0
`define CPUFIFO_SEL_STATUS 1'b1
`define CPUFIFO_STAT_TX_AVAIL 0
`define CPUFIFO_STAT_RX_ROOM 1
`define CPUFIFO_POWER_SUSPENDED 1'b1
`define CPUFIFO_POWER_ACTIVE 1'b0
`define CPUFIFO_BYTE_ZERO 8'h00
`endif

// [inc/cpufifo_pkg.sv]
// types of the processor-facing fifo port
package cpufifo_pkg;
  typedef enum logic [1:0] {
    CPUFIFO_IDLE,
    CPUFIFO_READ,
    CPUFIFO_WRITE
  } cpufifo_acc_type;
endpackage

// [logic/cpufifo_port.sv]
// processor-facing fifo port with transmit and receive buffers
// What this block does
// - port starts accesses and takes wake pulses only while the configuration selects this interface mode
// - eight-bit data bus, bit 7 most significant, bit 0 least
// - strobes count as accesses only while select is low
// - read strobe low puts one fifo byte (zero when empty) on the data bus with data selected, the status byte with status selected
// - write strobe low with data selected captures the bus byte into the fifo; status writes are dropped
// - wake pulse during suspend with remote wakeup enabled requests usb resume
// - send-immediate pulse while active flushes receive data on next bulk-in
// - one kilobyte transmit buffer and one kilobyte receive buffer
`include "cpufifo_params.svh"
module cpufifo_port import cpufifo_pkg::*; #(
  parameter int BUF_AW = `CPUFIFO_BUF_AW
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic cfg_cpu_mode_i,
  input wire logic cfg_remote_wake_i,
  input wire logic select_n_i,
  input wire logic register_select_bit_i,
  input wire logic read_n_i,
  input wire logic write_n_i,
  input wire logic [`CPUFIFO_DATA_W-1:0] host_data_bus_i,
  output logic [`CPUFIFO_DATA_W-1:0] host_data_bus_o,
  output logic host_data_bus_oe_n_o,
  input wire logic flush_or_wake_n_i,
  input wire logic usb_active_power_n_i,
  input wire logic usb_tx_valid_i,
  input wire logic [`CPUFIFO_DATA_W-1:0] usb_tx_data_i,
  output logic usb_tx_ready_o,
  output logic usb_rx_valid_o,
  output logic [`CPUFIFO_DATA_W-1:0] usb_rx_data_o,
  input wire logic usb_rx_ready_i,
  input wire logic usb_bulk_in_req_i,
  output logic usb_send_short_o,
  output logic usb_resume_req_o
);
  localparam int DW = `CPUFIFO_DATA_W;
  localparam int DEPTH = 1 << BUF_AW;

  // the buffer size is fixed by the device; refuse anything else
  if (DEPTH != `CPUFIFO_BUF_BYTES) begin : g_bad_depth
    $error("cpufifo_port: BUF_AW must give a 1 kbyte buffer");
  end

  // number of bytes held, from pointers with a wrap bit
  function automatic logic [BUF_AW:0] fill(input logic [BUF_AW:0] wp, input logic [BUF_AW:0] rp);
    fill = wp - rp;
  endfunction

  // pin synchronisers; stage one is read only by stage two
  logic [5+DW:0] pin_s1;
  logic [5+DW:0] pin_s2;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1 <= {1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, `CPUFIFO_BYTE_ZERO};
      pin_s2 <= {1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, `CPUFIFO_BYTE_ZERO};
    end else begin
      pin_s1 <= {select_n_i, flush_or_wake_n_i, usb_active_power_n_i, read_n_i, write_n_i,
                 register_select_bit_i, host_data_bus_i};
      pin_s2 <= pin_s1;
    end
  end
  logic s_sel_n, s_fw_n, s_pwr_n, s_rd_n, s_wr_n, s_a0;
  logic [DW-1:0] s_data;
  assign {s_sel_n, s_fw_n, s_pwr_n, s_rd_n, s_wr_n, s_a0, s_data} = pin_s2;

  // buffers: transmit holds usb-to-processor bytes, receive the other way
  // two 1k buffers
  logic [DW-1:0] tx_mem [DEPTH];
  logic [DW-1:0] rx_mem [DEPTH];

  // state
  cpufifo_acc_type acc, next_acc;
  logic [BUF_AW:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [BUF_AW:0] next_tx_wp, next_tx_rp, next_rx_wp, next_rx_rp;
  logic [DW-1:0] wr_byte, next_wr_byte;
  logic wr_status, next_wr_status;
  logic prev_fw_n, flush_pend, next_flush_pend;
  logic [DW-1:0] next_bus_o, next_rx_data;
  logic next_oe_n, next_tx_ready, next_rx_valid, next_short, next_resume;
  logic tx_push, rx_push, rx_pop;

  wire logic tx_empty = (fill(tx_wp, tx_rp) == '0);
  wire logic rx_full = (fill(rx_wp, rx_rp) == (BUF_AW + 1)'(DEPTH));
  wire logic tx_full = (fill(tx_wp, tx_rp) == (BUF_AW + 1)'(DEPTH));
  wire logic rx_empty = (rx_wp == rx_rp);
  // falling edge of the wake line; a held-low pin fires once
  wire logic fw_fall = prev_fw_n && !s_fw_n;

  // next-state logic of the port, buffers and usb side
  always_comb begin
    next_acc = acc;
    next_tx_wp = tx_wp;
    next_tx_rp = tx_rp;
    next_rx_wp = rx_wp;
    next_rx_rp = rx_rp;
    next_wr_byte = wr_byte;
    next_wr_status = wr_status;
    next_flush_pend = flush_pend;
    next_bus_o = host_data_bus_o;
    next_oe_n = 1'b1;
    next_short = 1'b0;
    next_resume = 1'b0;
    tx_push = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    case (acc)
      CPUFIFO_IDLE: begin
        if (cfg_cpu_mode_i && !s_sel_n && !s_rd_n) begin
          next_acc = CPUFIFO_READ;
          if (s_a0 == `CPUFIFO_SEL_STATUS) begin
            next_bus_o = `CPUFIFO_BYTE_ZERO;
            next_bus_o[`CPUFIFO_STAT_TX_AVAIL] = !tx_empty;
            next_bus_o[`CPUFIFO_STAT_RX_ROOM] = !rx_full;
          end else begin
            next_bus_o = tx_empty ? `CPUFIFO_BYTE_ZERO : tx_mem[tx_rp[BUF_AW-1:0]];
            if (!tx_empty) begin
              next_tx_rp = tx_rp + 1'b1;
            end
          end
          next_oe_n = 1'b0;
        end else if (cfg_cpu_mode_i && !s_sel_n && !s_wr_n) begin
          next_acc = CPUFIFO_WRITE;
          next_wr_status = (s_a0 == `CPUFIFO_SEL_STATUS);
          next_wr_byte = s_data;
        end
      end
      CPUFIFO_READ: begin
        // drive only while select and read low
        // leaving the mode also releases the bus at once
        if (s_sel_n || s_rd_n || !cfg_cpu_mode_i) begin
          next_acc = CPUFIFO_IDLE;
        end else begin
          next_oe_n = 1'b0;
        end
      end
      CPUFIFO_WRITE: begin
        // data keeps settling while strobe is low; last sample wins
        if (s_sel_n || s_wr_n) begin
          next_acc = CPUFIFO_IDLE;
          if (!wr_status && !rx_full) begin
            rx_push = 1'b1;
            next_rx_wp = rx_wp + 1'b1;
          end
        end else begin
          next_wr_byte = s_data;
        end
      end
      default: begin
        next_acc = CPUFIFO_IDLE;
      end
    endcase
    // usb side into the transmit buffer
    if (usb_tx_valid_i && usb_tx_ready_o) begin
      tx_push = 1'b1;
      next_tx_wp = tx_wp + 1'b1;
    end
    // usb side out of the receive buffer
    if (usb_rx_valid_o && usb_rx_ready_i) begin
      rx_pop = 1'b1;
      next_rx_rp = rx_rp + 1'b1;
    end
    if (cfg_cpu_mode_i && fw_fall && s_pwr_n == `CPUFIFO_POWER_SUSPENDED &&
        cfg_remote_wake_i) begin
      next_resume = 1'b1;
    end
    // flush on next bulk-in; a new pulse wins over the clear
    if (usb_bulk_in_req_i && flush_pend) begin
      next_short = 1'b1;
      next_flush_pend = 1'b0;
    end
    if (cfg_cpu_mode_i && fw_fall && s_pwr_n == `CPUFIFO_POWER_ACTIVE) begin
      next_flush_pend = 1'b1;
    end
    next_tx_ready = (fill(next_tx_wp, next_tx_rp) != (BUF_AW + 1)'(DEPTH));
    next_rx_valid = (next_rx_wp != next_rx_rp);
    next_rx_data = rx_mem[next_rx_rp[BUF_AW-1:0]];
    // the new head is the slot written at this edge; its ram copy is not there yet
    if (rx_push && (next_rx_rp == rx_wp)) begin
      next_rx_data = wr_byte;
    end
  end

  // buffer storage; no reset so it maps to ram
  always_ff @(posedge ref_clk_i) begin
    if (tx_push) begin
      tx_mem[tx_wp[BUF_AW-1:0]] <= usb_tx_data_i;
    end
    if (rx_push) begin
      rx_mem[rx_wp[BUF_AW-1:0]] <= wr_byte;
    end
  end

  // registered state and outputs
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc <= CPUFIFO_IDLE;
      tx_wp <= '0;
      tx_rp <= '0;
      rx_wp <= '0;
      rx_rp <= '0;
      wr_byte <= `CPUFIFO_BYTE_ZERO;
      wr_status <= 1'b0;
      prev_fw_n <= 1'b1;
      flush_pend <= 1'b0;
      host_data_bus_o <= `CPUFIFO_BYTE_ZERO;
      host_data_bus_oe_n_o <= 1'b1;
      usb_tx_ready_o <= 1'b0;
      usb_rx_valid_o <= 1'b0;
      usb_rx_data_o <= `CPUFIFO_BYTE_ZERO;
      usb_send_short_o <= 1'b0;
      usb_resume_req_o <= 1'b0;
    end else begin
      acc <= next_acc;
      tx_wp <= next_tx_wp;
      tx_rp <= next_tx_rp;
      rx_wp <= next_rx_wp;
      rx_rp <= next_rx_rp;
      wr_byte <= next_wr_byte;
      wr_status <= next_wr_status;
      prev_fw_n <= s_fw_n;
      flush_pend <= next_flush_pend;
      host_data_bus_o <= next_bus_o;
      host_data_bus_oe_n_o <= next_oe_n;
      usb_tx_ready_o <= next_tx_ready;
      usb_rx_valid_o <= next_rx_valid;
      usb_rx_data_o <= next_rx_data;
      usb_send_short_o <= next_short;
      usb_resume_req_o <= next_resume;
    end
  end
endmodule // cpufifo_port

// [verification/cpufifo_port_chk.sv]
// assertion checker for the processor fifo port
module cpufifo_port_chk (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic cfg_cpu_mode_i,
  input wire logic cfg_remote_wake_i,
  input wire logic select_n_i,
  input wire logic register_select_bit_i,
  input wire logic read_n_i,
  input wire logic write_n_i,
  input wire logic flush_or_wake_n_i,
  input wire logic usb_active_power_n_i,
  input wire logic usb_bulk_in_req_i,
  input wire logic host_data_bus_oe_n_o,
  input wire logic usb_rx_valid_o,
  input wire logic usb_send_short_o,
  input wire logic usb_resume_req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // read start and write end, seen before the pin synchroniser
  sequence s_rd_go; $fell(read_n_i) && !select_n_i && cfg_cpu_mode_i; endsequence
  sequence s_wr_end;
    $rose(write_n_i) && !$past(select_n_i) && !register_select_bit_i && cfg_cpu_mode_i &&
      !usb_rx_valid_o;
  endsequence
  property p_mode_off; !cfg_cpu_mode_i [*5] |-> host_data_bus_oe_n_o; endproperty
  a_mode_off: assert property (p_mode_off) else $error("bus driven in other mode");
  property p_sel_gate; select_n_i [*5] |-> host_data_bus_oe_n_o; endproperty
  a_sel_gate: assert property (p_sel_gate) else $error("bus driven unselected");
  property p_rd_gate; read_n_i [*5] |-> host_data_bus_oe_n_o; endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("bus driven without read");
  property p_rd_ans; s_rd_go |-> ##[2:4] !host_data_bus_oe_n_o; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_wr_rx; s_wr_end |-> ##[2:6] usb_rx_valid_o; endproperty
  a_wr_rx: assert property (p_wr_rx) else $error("written byte not queued");
  property p_wake;
    $fell(flush_or_wake_n_i) && usb_active_power_n_i && cfg_remote_wake_i && cfg_cpu_mode_i
      |-> ##[2:4] usb_resume_req_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no resume request");
  property p_wake_one; usb_resume_req_o |=> !usb_resume_req_o; endproperty
  a_wake_one: assert property (p_wake_one) else $error("resume pulse too long");
  property p_wake_off; !cfg_remote_wake_i [*4] |-> !usb_resume_req_o; endproperty
  a_wake_off: assert property (p_wake_off) else $error("resume while disabled");
  property p_short; usb_send_short_o |-> $past(usb_bulk_in_req_i); endproperty
  a_short: assert property (p_short) else $error("flush without bulk-in");
endmodule // cpufifo_port_chk
bind cpufifo_port cpufifo_port_chk u_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .cfg_cpu_mode_i(cfg_cpu_mode_i), .cfg_remote_wake_i(cfg_remote_wake_i),
  .select_n_i(select_n_i), .register_select_bit_i(register_select_bit_i),
  .read_n_i(read_n_i), .write_n_i(write_n_i), .flush_or_wake_n_i(flush_or_wake_n_i),
  .usb_active_power_n_i(usb_active_power_n_i), .usb_bulk_in_req_i(usb_bulk_in_req_i),
  .host_data_bus_oe_n_o(host_data_bus_oe_n_o), .usb_rx_valid_o(usb_rx_valid_o),
  .usb_send_short_o(usb_send_short_o), .usb_resume_req_o(usb_resume_req_o));

// [verification/cpufifo_cpu_model.sv]
// processor model that drives the fifo port pins
module cpufifo_cpu_model (
  input wire logic clk_i,
  input wire logic oe_n_i,
  input wire logic [7:0] dev_i,
  output logic sel_n_o,
  output logic a0_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [7:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv = 1'h0;
  logic [7:0] wd = 8'h00;
  logic [7:0] last = 8'h00;
  // wire level; a released bus toggles so no stale byte survives
  assign dq_o = !oe_n_i ? dev_i : (drv ? wd : ~last);
  always @(posedge clk_i) last <= dq_o;
  initial {sel_n_o, a0_o, rd_n_o, wr_n_o} = 4'hB;
  // strobe low four edges, byte taken, then high four
  task automatic acc(input logic rd, input logic a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk_i);
    {sel_n_o, a0_o, wd, drv, rd_n_o, wr_n_o} = {1'h0, a, d, !rd, !rd, rd};
    repeat (3) @(negedge clk_i);
    @(posedge clk_i);
    q = dq_o;
    @(negedge clk_i);
    {sel_n_o, rd_n_o, wr_n_o, drv} = 4'hE;
    repeat (4) @(negedge clk_i);
  endtask
endmodule // cpufifo_cpu_model

// [verification/tb_cpu_style_fifo_port.sv]
// testbench for the processor fifo port
module tb_cpu_style_fifo_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, nrst = 1'h0, mode = 1'h1, wk_en = 1'h1, fl_n = 1'h1, pw_n = 1'h0;
  logic tx_v = 1'h0, rx_rdy = 1'h0, bulk = 1'h0, sel_n, a0, rd_n, wr_n, oe_n;
  logic tx_rdy, rx_v, short_p, res_p;
  logic [7:0] tx_d = 8'h00, q, bus_o, dq, rx_d;
  int fail_count = 0, check_count = 0, n_res = 0, n_sh = 0;
  logic [7:0] rows [4] = '{8'h01, 8'h80, 8'hA5, 8'hFF};
  always #25 clk = ~clk;
  // count pulses at the falling edge, away from the edge that launches them
  always @(negedge clk) begin
    n_res += (res_p === 1'h1);
    n_sh += (short_p === 1'h1);
  end
  cpufifo_port u_dut (.ref_clk_i(clk), .nrst_i(nrst), .cfg_cpu_mode_i(mode),
    .cfg_remote_wake_i(wk_en), .select_n_i(sel_n), .register_select_bit_i(a0),
    .read_n_i(rd_n), .write_n_i(wr_n), .host_data_bus_i(dq), .host_data_bus_o(bus_o),
    .host_data_bus_oe_n_o(oe_n), .flush_or_wake_n_i(fl_n), .usb_active_power_n_i(pw_n),
    .usb_tx_valid_i(tx_v), .usb_tx_data_i(tx_d), .usb_tx_ready_o(tx_rdy),
    .usb_rx_valid_o(rx_v), .usb_rx_data_o(rx_d), .usb_rx_ready_i(rx_rdy),
    .usb_bulk_in_req_i(bulk), .usb_send_short_o(short_p), .usb_resume_req_o(res_p));
  cpufifo_cpu_model u_cpu (.clk_i(clk), .oe_n_i(oe_n), .dev_i(bus_o), .sel_n_o(sel_n),
    .a0_o(a0), .rd_n_o(rd_n), .wr_n_o(wr_n), .dq_o(dq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // wake pin strobed low three cycles, then settle
  task pulse;
    fl_n = 1'h0;
    repeat (3) @(negedge clk);
    fl_n = 1'h1;
    repeat (6) @(negedge clk);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'h1;
    repeat (4) @(negedge clk);
    chk({6'h00, oe_n, tx_rdy}, 8'h03);
    $display("reset test done");
    // byte from usb read back, byte written seen by usb, status read first
    foreach (rows[i]) begin
      {tx_v, tx_d} = {1'h1, rows[i]};
      @(negedge clk);
      tx_v = 1'h0;
      u_cpu.acc(1'h1, 1'h1, 8'h00, q);
      chk(q, 8'h03);
      u_cpu.acc(1'h1, 1'h0, 8'h00, q);
      chk(q, rows[i]);
      u_cpu.acc(1'h0, 1'h0, ~rows[i], q);
      chk(rx_d, ~rows[i]);
      rx_rdy = 1'h1;
      @(negedge clk);
      rx_rdy = 1'h0;
    end
    $display("row test done");
    // empty read gives zero; status write and other-mode accesses dropped
    u_cpu.acc(1'h1, 1'h0, 8'h00, q);
    chk(q, 8'h00);
    u_cpu.acc(1'h0, 1'h1, 8'h5A, q);
    mode = 1'h0;
    u_cpu.acc(1'h0, 1'h0, 8'h5A, q);
    u_cpu.acc(1'h1, 1'h0, 8'h00, q);
    mode = 1'h1;
    chk({7'h00, rx_v}, 8'h00);
    $display("refusal test done");
    // suspended: one resume, none with wakeup disabled
    pw_n = 1'h1;
    repeat (4) @(negedge clk);
    pulse();
    wk_en = 1'h0;
    pulse();
    chk(8'(n_res), 8'h01);
    // active: flush waits for bulk-in, then clears
    {pw_n, wk_en} = 2'h1;
    repeat (4) @(negedge clk);
    pulse();
    chk(8'(n_sh), 8'h00);
    repeat (2) begin
      bulk = 1'h1;
      @(negedge clk);
      bulk = 1'h0;
      repeat (3) @(negedge clk);
    end
    chk(8'(n_sh + n_res), 8'h02);
    // a new pulse in the very cycle that bulk-in clears the flush: set wins
    pulse();
    fl_n = 1'h0;
    repeat (2) @(negedge clk);
    bulk = 1'h1;
    @(negedge clk);
    {fl_n, bulk} = 2'h2;
    repeat (6) @(negedge clk);
    bulk = 1'h1;
    @(negedge clk);
    bulk = 1'h0;
    repeat (3) @(negedge clk);
    chk(8'(n_sh), 8'h03);
    $display("wake test done");
    final_report();
  end
endmodule // tb_cpu_style_fifo_port
